// File: rtl/pfsa_params.svh
/*
  Constants of the program flash self-access block: pointer and block
  geometry, unlock keys, control bit positions, timing and host offsets.
  Assumes inclusion by bare name from the flash end and core end design files.
*/
`ifndef PFSA_PARAMS_SVH
`define PFSA_PARAMS_SVH

// Geometry
`define PFSA_BLOCK_BYTES   64
`define PFSA_PTR_W         22
`define PFSA_HOLD_RESET    8'hFF

// Timing: 25 MHz clock, about 2 ms long write
`define PFSA_CLK_KHZ       25000
`define PFSA_LONG_WRITE_US 2000
`define PFSA_LONG_CYCLES   ((`PFSA_LONG_WRITE_US * `PFSA_CLK_KHZ) / 1000)

// Unlock keys
`define PFSA_KEY_FIRST     8'h55
`define PFSA_KEY_SECOND    8'hAA

// Memory control and interrupt register bit positions
`define PFSA_CTRL_PGM      7
`define PFSA_CTRL_CFG      6
`define PFSA_CTRL_ERASE    4
`define PFSA_CTRL_ABORT    3
`define PFSA_CTRL_PERMIT   2
`define PFSA_CTRL_START    1
`define PFSA_IRQ_DONE      0

// Host APB map
`define PFSA_APB_CMD       12'h000
`define PFSA_APB_STAT      12'h004

// Command word fields
`define PFSA_CMD_OP_LSB    0
`define PFSA_CMD_REG_LSB   2
`define PFSA_CMD_MODE_LSB  5
`define PFSA_CMD_DATA_LSB  8

// Status word fields
`define PFSA_STAT_PEND     0
`define PFSA_STAT_STALL    1
`define PFSA_STAT_VALID    2
`define PFSA_STAT_DATA_LSB 8

`endif

// File: rtl/pfsa_pkg.sv
/*
  Types shared by both ends of the program flash self-access link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pfsa_pkg;

  typedef enum logic [1:0] {
    PFSA_CMD_RD,
    PFSA_CMD_WT,
    PFSA_CMD_REGWR,
    PFSA_CMD_REGRD
  } pfsa_cmd_t;

  typedef enum logic [2:0] {
    PFSA_REG_PTRL,
    PFSA_REG_PTRH,
    PFSA_REG_PTRU,
    PFSA_REG_LATCH,
    PFSA_REG_CTRL,
    PFSA_REG_KEY,
    PFSA_REG_IRQ
  } pfsa_reg_t;

  typedef enum logic [1:0] {
    PFSA_PTR_KEEP,
    PFSA_PTR_POSTINC,
    PFSA_PTR_POSTDEC,
    PFSA_PTR_PREINC
  } pfsa_mode_t;

  typedef enum logic [1:0] {
    PFSA_ST_IDLE,
    PFSA_ST_RDWAIT,
    PFSA_ST_LONG
  } pfsa_state_t;

endpackage

// File: rtl/pfsa_if.sv
/*
  Link between the core end (table operations, register accesses) and the
  flash end. Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface pfsa_if;
  logic                 req;
  pfsa_pkg::pfsa_cmd_t  cmd;
  pfsa_pkg::pfsa_reg_t  rsel;
  pfsa_pkg::pfsa_mode_t mode;
  logic [7:0]           wdata;
  logic                 ready;
  logic                 rvalid;
  logic [7:0]           rdata;
  logic                 busy;

  modport core  (output req, cmd, rsel, mode, wdata, input ready, rvalid, rdata, busy);
  modport flash (input req, cmd, rsel, mode, wdata, output ready, rvalid, rdata, busy);
endinterface

`default_nettype wire

// File: rtl/pfsa_flash_end.sv
/*
  Flash end: table pointer, table latch, memory control, unlock keys,
  holding registers and the timed long write. Assumes a flash array that
  reads a word in the same cycle as its address and ANDs programmed data in.
*/
// Summary of operation
// - Table read fetches one byte into latch
// - Table read variant may update pointer
// - Address bit zero picks high/low byte
// - Erase clears one whole 64-byte block
// - Erase block from pointer bits 21:6
// - Firmware sets select, permit, erase bits first
// - Keys 55h then AAh, then start
// - Start after unlock with erase erases block
// - Core stalls until timer ends long write
// - Firmware clears config select, masks interrupts
// - Programming always covers a 64-byte block
// - One holding register per block byte
// - Table writes touch holding registers only
// - Holding registers FFh after reset, program
// - FFh holding byte leaves flash unchanged
// - On-chip timer sets long write length
// - No self-initiated erase beyond one block
// - Start bit set by software, hardware clears
// - Completion sets done flag until cleared
// - Abort flag on cut-short or improper write
// - Low pointer bits pick holding register
`timescale 1ns/10ps
`default_nettype none
`include "pfsa_params.svh"

module pfsa_flash_end
  import pfsa_pkg::*;
#(
  parameter int BLOCK_BYTES = `PFSA_BLOCK_BYTES,
  parameter int PTR_W       = `PFSA_PTR_W,
  parameter int LONG_CYCLES = `PFSA_LONG_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  input  wire logic                     CE,
  // Core link
  pfsa_if.flash                         core,
  // Flash array
  output logic [PTR_W-2:0]              FL_ADDR,
  input  wire logic [15:0]              FL_RDATA,
  output logic                          FL_ERASE,
  output logic                          FL_PROG,
  output logic [PTR_W-$clog2(BLOCK_BYTES)-1:0] FL_BLOCK,
  output logic [8*BLOCK_BYTES-1:0]      FL_DATA,
  output logic                          FL_BUSY,
  // Completion flag
  output logic                          NVM_DONE
);
  localparam int BLK_LSB = $clog2(BLOCK_BYTES);
  localparam int CNT_W   = $clog2(LONG_CYCLES + 1);

  initial begin
    if ((1 << BLK_LSB) != BLOCK_BYTES || BLK_LSB < 1 || PTR_W <= BLK_LSB + 1 || PTR_W > 24)
      $error("pfsa_flash_end: unsupported block or pointer size");
    if (LONG_CYCLES < 1)
      $error("pfsa_flash_end: long write needs at least one cycle");
  end

  // Only the low PTR_W-1 bits step; the top bit selects the ID space
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic up);
    logic [PTR_W-2:0] low;
    low = up ? p[PTR_W-2:0] + 1'b1 : p[PTR_W-2:0] - 1'b1;
    return {p[PTR_W-1], low};
  endfunction

  pfsa_state_t      state_q, state_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic [7:0]       latch_q, latch_d;
  logic [7:0]       hold_q [BLOCK_BYTES];
  logic [7:0]       hold_d [BLOCK_BYTES];
  logic [1:0]       key_q, key_d;
  logic             erase_q, erase_d;
  logic             permit_q, permit_d;
  logic             start_q, start_d;
  logic             done_q, done_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PTR_W-2:0] addr_q, addr_d;
  logic             hisel_q, hisel_d;
  logic             ferase_q, ferase_d;
  logic             fprog_q, fprog_d;
  logic [PTR_W-BLK_LSB-1:0] blk_q, blk_d;
  logic             rvalid_q, rvalid_d;
  logic [7:0]       rdata_q, rdata_d;
  // Left unreset on purpose so a reset during a long write stays visible
  logic             pgm_q, pgm_d;
  logic             cfg_q, cfg_d;
  logic             abort_q, abort_d;

  logic [PTR_W-1:0] eff;
  logic             accept;

  always_comb begin
    state_d  = state_q;
    ptr_d    = ptr_q;
    latch_d  = latch_q;
    hold_d   = hold_q;
    key_d    = key_q;
    erase_d  = erase_q;
    permit_d = permit_q;
    start_d  = start_q;
    done_d   = done_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    hisel_d  = hisel_q;
    ferase_d = 1'b0;
    fprog_d  = 1'b0;
    blk_d    = blk_q;
    rvalid_d = 1'b0;
    rdata_d  = rdata_q;
    pgm_d    = pgm_q;
    cfg_d    = cfg_q;
    abort_d  = abort_q;
    accept   = core.req && state_q == PFSA_ST_IDLE;
    eff      = (core.mode == PFSA_PTR_PREINC) ? ptr_step(ptr_q, 1'b1) : ptr_q;

    unique case (state_q)
      PFSA_ST_IDLE: begin
        if (accept) begin
          key_d = 2'd0;
          unique case (core.cmd)
            PFSA_CMD_RD: begin
              addr_d  = eff[PTR_W-1:1];
              hisel_d = eff[0];
              state_d = PFSA_ST_RDWAIT;
            end
            PFSA_CMD_WT: begin
              hold_d[eff[BLK_LSB-1:0]] = latch_q;
            end
            PFSA_CMD_REGWR: begin
              unique case (core.rsel)
                PFSA_REG_PTRL:  ptr_d[7:0]  = core.wdata;
                PFSA_REG_PTRH:  ptr_d[15:8] = core.wdata;
                PFSA_REG_PTRU:  ptr_d[PTR_W-1:16] = core.wdata[PTR_W-17:0];
                PFSA_REG_LATCH: latch_d = core.wdata;
                PFSA_REG_KEY: begin
                  // A repeated first key restarts the sequence rather than killing it
                  if (core.wdata == `PFSA_KEY_FIRST)
                    key_d = 2'd1;
                  else if (key_q == 2'd1 && core.wdata == `PFSA_KEY_SECOND)
                    key_d = 2'd2;
                end
                PFSA_REG_IRQ: begin
                  if (!core.wdata[`PFSA_IRQ_DONE])
                    done_d = 1'b0;
                end
                PFSA_REG_CTRL: begin
                  pgm_d    = core.wdata[`PFSA_CTRL_PGM];
                  cfg_d    = core.wdata[`PFSA_CTRL_CFG];
                  erase_d  = core.wdata[`PFSA_CTRL_ERASE];
                  permit_d = core.wdata[`PFSA_CTRL_PERMIT];
                  abort_d  = core.wdata[`PFSA_CTRL_ABORT];
                  // Writing zero to start is ignored
                  if (core.wdata[`PFSA_CTRL_START]) begin
                    if (core.wdata[`PFSA_CTRL_PERMIT] && key_q == 2'd2 &&
                        core.wdata[`PFSA_CTRL_PGM] && !core.wdata[`PFSA_CTRL_CFG]) begin
                      start_d  = 1'b1;
                      abort_d  = 1'b1;
                      state_d  = PFSA_ST_LONG;
                      cnt_d    = CNT_W'(LONG_CYCLES - 1);
                      blk_d    = ptr_q[PTR_W-1:BLK_LSB];
                      ferase_d = core.wdata[`PFSA_CTRL_ERASE];
                      fprog_d  = !core.wdata[`PFSA_CTRL_ERASE];
                    end else begin
                      abort_d = 1'b1;
                    end
                  end
                end
                default: ;
              endcase
            end
            PFSA_CMD_REGRD: begin
              rvalid_d = 1'b1;
              unique case (core.rsel)
                PFSA_REG_PTRL:  rdata_d = ptr_q[7:0];
                PFSA_REG_PTRH:  rdata_d = ptr_q[15:8];
                PFSA_REG_PTRU:  rdata_d = 8'(ptr_q[PTR_W-1:16]);
                PFSA_REG_LATCH: rdata_d = latch_q;
                PFSA_REG_CTRL:  rdata_d = {pgm_q, cfg_q, 1'b0, erase_q, abort_q,
                                           permit_q, start_q, 1'b0};
                PFSA_REG_IRQ:   rdata_d = {7'h00, done_q};
                default:        rdata_d = 8'h00;
              endcase
            end
          endcase
          // Pointer update for table operations
          if (core.cmd == PFSA_CMD_RD || core.cmd == PFSA_CMD_WT) begin
            unique case (core.mode)
              PFSA_PTR_POSTINC: ptr_d = ptr_step(ptr_q, 1'b1);
              PFSA_PTR_POSTDEC: ptr_d = ptr_step(ptr_q, 1'b0);
              PFSA_PTR_PREINC:  ptr_d = eff;
              PFSA_PTR_KEEP:    ptr_d = ptr_q;
            endcase
          end
        end
      end
      PFSA_ST_RDWAIT: begin
        latch_d  = hisel_q ? FL_RDATA[15:8] : FL_RDATA[7:0];
        rdata_d  = latch_d;
        rvalid_d = 1'b1;
        state_d  = PFSA_ST_IDLE;
      end
      PFSA_ST_LONG: begin
        if (cnt_q == '0) begin
          state_d = PFSA_ST_IDLE;
          start_d = 1'b0;
          erase_d = 1'b0;
          abort_d = 1'b0;
          done_d  = 1'b1;
          if (!erase_q) begin
            for (int i = 0; i < BLOCK_BYTES; i++) begin
              hold_d[i] = `PFSA_HOLD_RESET;
            end
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = PFSA_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q  <= PFSA_ST_IDLE;
      ptr_q    <= '0;
      latch_q  <= 8'h00;
      key_q    <= 2'd0;
      erase_q  <= 1'b0;
      permit_q <= 1'b0;
      start_q  <= 1'b0;
      done_q   <= 1'b0;
      cnt_q    <= '0;
      addr_q   <= '0;
      hisel_q  <= 1'b0;
      ferase_q <= 1'b0;
      fprog_q  <= 1'b0;
      blk_q    <= '0;
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      for (int i = 0; i < BLOCK_BYTES; i++) begin
        hold_q[i] <= `PFSA_HOLD_RESET;
      end
    end else if (CE) begin
      state_q  <= state_d;
      ptr_q    <= ptr_d;
      latch_q  <= latch_d;
      key_q    <= key_d;
      erase_q  <= erase_d;
      permit_q <= permit_d;
      start_q  <= start_d;
      done_q   <= done_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      hisel_q  <= hisel_d;
      ferase_q <= ferase_d;
      fprog_q  <= fprog_d;
      blk_q    <= blk_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      hold_q   <= hold_d;
    end
  end

  // Selects and abort flag survive reset
  always_ff @(posedge CLK) begin
    if (CE) begin
      pgm_q   <= pgm_d;
      cfg_q   <= cfg_d;
      abort_q <= abort_d;
    end
  end

  // Bytes left at FFh program nothing in the AND-ing array
  for (genvar g = 0; g < BLOCK_BYTES; g++) begin : g_pack
    assign FL_DATA[8*g +: 8] = hold_q[g];
  end

  assign core.ready  = (state_q == PFSA_ST_IDLE);
  assign core.busy   = (state_q == PFSA_ST_LONG);
  assign core.rvalid = rvalid_q;
  assign core.rdata  = rdata_q;
  assign FL_ADDR     = addr_q;
  assign FL_ERASE    = ferase_q;
  assign FL_PROG     = fprog_q;
  assign FL_BLOCK    = blk_q;
  assign FL_BUSY     = core.busy;
  assign NVM_DONE    = done_q;
endmodule

`default_nettype wire

// File: rtl/pfsa_core_end.sv
/*
  Core end: takes table and register orders from software over APB and
  issues them on the link, one at a time. Assumes an APB master on CLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pfsa_params.svh"

module pfsa_core_end
  import pfsa_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Flash link
  pfsa_if.core             core
);
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        req_q, req_d;
  pfsa_cmd_t   cmd_q, cmd_d;
  pfsa_reg_t   rsel_q, rsel_d;
  pfsa_mode_t  mode_q, mode_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        valid_q, valid_d;
  logic [7:0]  result_q, result_d;
  logic        acc;

  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    req_d     = req_q;
    cmd_d     = cmd_q;
    rsel_d    = rsel_q;
    mode_d    = mode_q;
    wdata_d   = wdata_q;
    valid_d   = valid_q;
    result_d  = result_q;
    acc       = PSEL && PENABLE && !pready_q;
    // Order leaves once the flash end takes it
    if (req_q && core.ready)
      req_d = 1'b0;
    if (acc) begin
      pready_d = 1'b1;
      if (PADDR == `PFSA_APB_CMD && PWRITE) begin
        // A second order while one is pending is refused, not queued
        if (req_q) begin
          pslverr_d = 1'b1;
        end else begin
          req_d   = 1'b1;
          cmd_d   = pfsa_cmd_t'(PWDATA[`PFSA_CMD_OP_LSB +: 2]);
          rsel_d  = pfsa_reg_t'(PWDATA[`PFSA_CMD_REG_LSB +: 3]);
          mode_d  = pfsa_mode_t'(PWDATA[`PFSA_CMD_MODE_LSB +: 2]);
          wdata_d = PWDATA[`PFSA_CMD_DATA_LSB +: 8];
          valid_d = 1'b0;
        end
      end else if (PADDR == `PFSA_APB_STAT && !PWRITE) begin
        prdata_d[`PFSA_STAT_PEND]         = req_q;
        prdata_d[`PFSA_STAT_STALL]        = core.busy;
        prdata_d[`PFSA_STAT_VALID]        = valid_q;
        prdata_d[`PFSA_STAT_DATA_LSB +: 8] = result_q;
        valid_d = 1'b0;
      end else if (PADDR != `PFSA_APB_CMD) begin
        pslverr_d = 1'b1;
      end
    end
    // A new result wins over the read that clears the valid bit
    if (core.rvalid) begin
      valid_d  = 1'b1;
      result_d = core.rdata;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      req_q     <= 1'b0;
      cmd_q     <= PFSA_CMD_RD;
      rsel_q    <= PFSA_REG_PTRL;
      mode_q    <= PFSA_PTR_KEEP;
      wdata_q   <= 8'h00;
      valid_q   <= 1'b0;
      result_q  <= 8'h00;
    end else if (CE) begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      req_q     <= req_d;
      cmd_q     <= cmd_d;
      rsel_q    <= rsel_d;
      mode_q    <= mode_d;
      wdata_q   <= wdata_d;
      valid_q   <= valid_d;
      result_q  <= result_d;
    end
  end

  assign PREADY     = pready_q;
  assign PSLVERR    = pslverr_q;
  assign PRDATA     = prdata_q;
  assign core.req   = req_q;
  assign core.cmd   = cmd_q;
  assign core.rsel  = rsel_q;
  assign core.mode  = mode_q;
  assign core.wdata = wdata_q;
endmodule

`default_nettype wire

// File: testbench/pfsa_assertions.sv
/*
  Concurrent checks on the link between the core end and the flash end.
  Assumes one clock and the link signals fed in as plain inputs.
*/
`timescale 1ns/10ps
`default_nettype none

module pfsa_assertions
  import pfsa_pkg::*;
#(
  parameter int BLOCK_BYTES = 64,
  parameter int LONG_CYCLES = 16
) (
  // Clock and reset
  input wire logic                   CLK,
  input wire logic                   RESET,
  input wire logic                   CE,
  // Link
  input wire logic                   req,
  input wire pfsa_cmd_t              cmd,
  input wire pfsa_reg_t              rsel,
  input wire logic [7:0]             wdata,
  input wire logic                   ready,
  input wire logic                   rvalid,
  input wire logic                   busy,
  // Array side
  input wire logic                   FL_PROG,
  input wire logic                   FL_ERASE,
  input wire logic [8*BLOCK_BYTES-1:0] FL_DATA,
  input wire logic                   NVM_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  logic        take;
  logic [1:0]  key_q;
  logic [1:0]  key_d;
  logic [31:0] bcnt_q;
  logic [31:0] bcnt_d;
  logic        prog_q;
  logic        prog_d;

  assign take = req && ready;

  // Key state follows link orders only; APB polling never disturbs it
  always_comb begin
    key_d = key_q;
    // Frozen cycles do not count towards the long write timer
    bcnt_d = busy ? bcnt_q + (CE ? 32'd1 : 32'd0) : 32'd0;
    prog_d = FL_PROG || (prog_q && !FL_ERASE);
    if (take) begin
      key_d = 2'd0;
      if (cmd == PFSA_CMD_REGWR && rsel == PFSA_REG_KEY && wdata == 8'h55)
        key_d = 2'd1;
      if (cmd == PFSA_CMD_REGWR && rsel == PFSA_REG_KEY && wdata == 8'hAA && key_q == 2'd1)
        key_d = 2'd2;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      key_q <= 2'd0;
      bcnt_q <= 32'd0;
      prog_q <= 1'b0;
    end else begin
      key_q <= key_d;
      bcnt_q <= bcnt_d;
      prog_q <= prog_d;
    end
  end

  sequence s_start;
    take && cmd == PFSA_CMD_REGWR && rsel == PFSA_REG_CTRL && wdata[1];
  endsequence
  sequence s_armed;
    s_start ##0 (key_q == 2'd2 && wdata[7] && !wdata[6] && wdata[2]);
  endsequence

  a_start_unlocked: assert property (s_armed |=> busy && FL_ERASE == $past(wdata[4]) && FL_PROG != $past(wdata[4]))
    else $error("unlocked start did not launch the right long write");
  a_start_locked: assert property (s_start ##0 key_q != 2'd2 |=> !busy && !FL_PROG && !FL_ERASE)
    else $error("long write began without the key sequence");
  a_busy_bound: assert property (busy |-> bcnt_q < LONG_CYCLES)
    else $error("long write ran past its timer");
  a_busy_length: assert property ($fell(busy) |-> $past(bcnt_q) == LONG_CYCLES - 1)
    else $error("long write ended early");
  a_core_stalled: assert property (busy |-> !ready)
    else $error("link took orders during a long write");
  a_read_answer: assert property (take && cmd == PFSA_CMD_RD |-> ##1 !rvalid ##1 rvalid)
    else $error("table read answer not two cycles after take");
  a_done_set: assert property ($fell(busy) |-> NVM_DONE)
    else $error("done flag not set at completion");
  a_done_hold: assert property (NVM_DONE && !(take && cmd == PFSA_CMD_REGWR && rsel == PFSA_REG_IRQ) |=> NVM_DONE)
    else $error("done flag dropped without a clear");
  a_hold_refill: assert property ($fell(busy) && prog_q |-> &FL_DATA)
    else $error("holding bytes not back to FFh after program");
  a_table_short: assert property (take && cmd == PFSA_CMD_WT |=> !FL_PROG && !FL_ERASE && !busy)
    else $error("table write touched the array");
endmodule

`default_nettype wire

// File: testbench/testbench.sv
/*
  Testbench: both ends joined by the link, driven over APB, with a simple
  array model. Assumes the package, interface and both ends compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import pfsa_pkg::*;

  // Short timer keeps the long write brief in simulation
  localparam int LONG = 12;

  logic         CLK;
  logic         RESET;
  logic         CE;
  logic         PSEL;
  logic         PENABLE;
  logic         PWRITE;
  logic [11:0]  PADDR;
  logic [31:0]  PWDATA;
  logic [31:0]  PRDATA;
  logic         PREADY;
  logic         PSLVERR;
  logic [20:0]  FL_ADDR;
  logic [15:0]  FL_RDATA;
  logic         FL_ERASE;
  logic         FL_PROG;
  logic [15:0]  FL_BLOCK;
  logic [511:0] FL_DATA;
  logic         FL_BUSY;
  logic         NVM_DONE;
  logic [7:0]   v;
  logic [15:0]  blk;
  logic [31:0]  q;
  logic         e;
  int           error_cnt;
  int           n_checks;
  int           n_prog;
  int           n_erase;
  int           bcnt;
  int           blen;

  pfsa_if pfsa_if_i ();

  pfsa_core_end pfsa_core_end_i (.CLK(CLK), .RESET(RESET), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .core(pfsa_if_i.core));

  pfsa_flash_end #(.LONG_CYCLES(LONG)) pfsa_flash_end_i (.CLK(CLK), .RESET(RESET), .CE(CE),
    .core(pfsa_if_i.flash), .FL_ADDR(FL_ADDR), .FL_RDATA(FL_RDATA), .FL_ERASE(FL_ERASE),
    .FL_PROG(FL_PROG), .FL_BLOCK(FL_BLOCK), .FL_DATA(FL_DATA), .FL_BUSY(FL_BUSY),
    .NVM_DONE(NVM_DONE));

  pfsa_assertions #(.BLOCK_BYTES(64), .LONG_CYCLES(LONG)) pfsa_assertions_i (.CLK(CLK),
    .RESET(RESET), .CE(CE), .req(pfsa_if_i.req), .cmd(pfsa_if_i.cmd), .rsel(pfsa_if_i.rsel),
    .wdata(pfsa_if_i.wdata), .ready(pfsa_if_i.ready), .rvalid(pfsa_if_i.rvalid),
    .busy(pfsa_if_i.busy), .FL_PROG(FL_PROG), .FL_ERASE(FL_ERASE), .FL_DATA(FL_DATA),
    .NVM_DONE(NVM_DONE));

  // Array word content follows its own address, so any byte is predictable
  assign FL_RDATA = {FL_ADDR[7:0] ^ 8'hA5, FL_ADDR[7:0]};

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (FL_PROG === 1'b1) begin
      n_prog++;
      blk = FL_BLOCK;
    end
    if (FL_ERASE === 1'b1) begin
      n_erase++;
      blk = FL_BLOCK;
    end
    if (pfsa_if_i.busy === 1'b1)
      bcnt++;
    else if (bcnt != 0) begin
      blen = bcnt;
      bcnt = 0;
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      test_done();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Poll status until the order is gone, any stall is over and, if asked, its result is back
  task automatic order(input pfsa_cmd_t c, input pfsa_reg_t r, input pfsa_mode_t m,
                       input logic [7:0] d);
    int n;
    apb(1'b1, 12'h000, {16'h0000, d, 1'b0, m, r, c});
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0000_0000);
      n++;
    end while ((q[0] !== 1'b0 || q[1] !== 1'b0 ||
                (c inside {PFSA_CMD_RD, PFSA_CMD_REGRD} && q[2] !== 1'b1)) && n < 100);
    if (n >= 100) begin
      error_cnt++;
      test_done();
    end
    v = q[15:8];
  endtask

  task automatic setp(input logic [21:0] p);
    order(PFSA_CMD_REGWR, PFSA_REG_PTRL, PFSA_PTR_KEEP, p[7:0]);
    order(PFSA_CMD_REGWR, PFSA_REG_PTRH, PFSA_PTR_KEEP, p[15:8]);
    order(PFSA_CMD_REGWR, PFSA_REG_PTRU, PFSA_PTR_KEEP, {2'b00, p[21:16]});
  endtask

  task automatic keys(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl);
    order(PFSA_CMD_REGWR, PFSA_REG_KEY, PFSA_PTR_KEEP, k1);
    order(PFSA_CMD_REGWR, PFSA_REG_KEY, PFSA_PTR_KEEP, k2);
    order(PFSA_CMD_REGWR, PFSA_REG_CTRL, PFSA_PTR_KEEP, ctl);
  endtask

  initial begin
    RESET = 1'b1;
    CE = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    {error_cnt, n_checks, n_prog, n_erase, bcnt, blen} = '0;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    chk("hold_reset", 1, &FL_DATA);
    setp(22'h00_0103);
    order(PFSA_CMD_RD, PFSA_REG_PTRL, PFSA_PTR_POSTINC, 8'h00);
    chk("read_odd", 8'h24, v);
    order(PFSA_CMD_RD, PFSA_REG_PTRL, PFSA_PTR_KEEP, 8'h00);
    chk("read_even", 8'h82, v);
    order(PFSA_CMD_REGRD, PFSA_REG_LATCH, PFSA_PTR_KEEP, 8'h00);
    chk("latch", 8'h82, v);
    order(PFSA_CMD_REGRD, PFSA_REG_PTRL, PFSA_PTR_KEEP, 8'h00);
    chk("ptr_low", 8'h04, v);
    setp(22'h15_5A45);
    order(PFSA_CMD_REGWR, PFSA_REG_LATCH, PFSA_PTR_KEEP, 8'h3C);
    order(PFSA_CMD_WT, PFSA_REG_PTRL, PFSA_PTR_POSTINC, 8'h00);
    order(PFSA_CMD_REGWR, PFSA_REG_LATCH, PFSA_PTR_KEEP, 8'h00);
    order(PFSA_CMD_WT, PFSA_REG_PTRL, PFSA_PTR_KEEP, 8'h00);
    chk("hold_5", 8'h3C, FL_DATA[47:40]);
    chk("hold_6", 8'h00, FL_DATA[55:48]);
    chk("hold_7", 8'hFF, FL_DATA[63:56]);
    chk("no_prog", 0, n_prog);
    order(PFSA_CMD_REGWR, PFSA_REG_CTRL, PFSA_PTR_KEEP, 8'h86);
    chk("no_keys", 0, n_prog);
    order(PFSA_CMD_REGRD, PFSA_REG_CTRL, PFSA_PTR_KEEP, 8'h00);
    chk("abort_set", 1, v[3]);
    keys(8'hAA, 8'h55, 8'h86);
    chk("bad_order", 0, n_prog);
    keys(8'h55, 8'hAA, 8'h86);
    chk("prog_once", 1, n_prog);
    chk("prog_block", 16'h5569, blk);
    chk("prog_len", LONG, blen);
    chk("done_prog", 1, NVM_DONE);
    chk("hold_refill", 1, &FL_DATA);
    order(PFSA_CMD_REGRD, PFSA_REG_CTRL, PFSA_PTR_KEEP, 8'h00);
    chk("start_clear", 2'b00, {v[3], v[1]});
    order(PFSA_CMD_REGWR, PFSA_REG_IRQ, PFSA_PTR_KEEP, 8'h00);
    chk("done_clear", 0, NVM_DONE);
    setp(22'h2A_BCFF);
    keys(8'h55, 8'hAA, 8'h96);
    chk("erase_once", 1, n_erase);
    chk("erase_block", 16'hAAF3, blk);
    chk("erase_len", LONG, blen);
    order(PFSA_CMD_REGRD, PFSA_REG_CTRL, PFSA_PTR_KEEP, 8'h00);
    chk("erase_sel", 0, v[4]);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped", 1, e);
    apb(1'b1, 12'h004, 32'h0000_0000);
    chk("status_ro", 1, e);
    // Start a program, freeze it with CE, then cut it short by reset
    order(PFSA_CMD_REGWR, PFSA_REG_KEY, PFSA_PTR_KEEP, 8'h55);
    order(PFSA_CMD_REGWR, PFSA_REG_KEY, PFSA_PTR_KEEP, 8'hAA);
    apb(1'b1, 12'h000, 32'h0000_8612);
    CE <= 1'b0;
    repeat (2 * LONG) @(posedge CLK);
    chk("ce_freeze", 1, FL_BUSY);
    RESET <= 1'b1;
    CE <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    chk("reset_busy", 0, FL_BUSY);
    order(PFSA_CMD_REGRD, PFSA_REG_CTRL, PFSA_PTR_KEEP, 8'h00);
    chk("reset_abort", 1, v[3]);
    chk("reset_select", 1, v[7]);
    test_done();
  end
endmodule

`default_nettype wire
